// File: src/reset_bus_pkg.sv
// shared types and constants for the reset intake and bus-state control block
// assumes one 100 MHz clock; the core bus request comes from logic on that clock
package reset_bus_pkg;
   localparam int AD_WIDTH = 16;
   localparam int UPPER_WIDTH = 3;
   localparam int SYNC_STAGES = 2;
   localparam int SYNC_WIDTH = 2;
   // synchroniser lane positions
   localparam int SYNC_RESET_BIT = 0;
   localparam int SYNC_STRAP_BIT = 1;
   // values after reset: reset seen active, strap idle high
   localparam logic [SYNC_WIDTH-1:0] SYNC_RESET_VAL = 2'h2;
   localparam logic [AD_WIDTH-1:0] AD_ZERO = 16'h0000;
   localparam logic [UPPER_WIDTH-1:0] UPPER_ZERO = 3'h0;
   // float cycles before release, so the synced strap lane shows a pulled-up pin level
   localparam logic [1:0] FLOAT_SETTLE = 2'h2;

   typedef enum logic [1:0] {st_run, st_park, st_float} seq_state_t;

   // request from the core's bus unit, one cycle of bus timing per clock
   typedef struct packed {
      logic active;
      logic is_read;
      logic is_write;
      logic ale;
      logic t1;
      logic halt;
      logic powerdown;
      logic idle;
      logic lock;
      logic ad_en;
      logic [AD_WIDTH-1:0] ad;
      logic [UPPER_WIDTH-1:0] upper;
      logic top_addr;
   } core_bus_t;

   // pin-side drive; every two-way pin has value and enable
   typedef struct packed {
      logic [AD_WIDTH-1:0] ad_out;
      logic ad_oe;
      logic [UPPER_WIDTH-1:0] upper_out;
      logic upper_oe;
      logic strap_out;
      logic strap_oe;
      logic lock_n_out;
      logic lock_oe;
      logic rd_n;
      logic wr_n;
      logic ale;
      logic ctl_oe;
      logic pullup_en;
   } bus_pins_t;

   localparam bus_pins_t PINS_RESET = '{
      ad_out: AD_ZERO, ad_oe: 1'b0, upper_out: UPPER_ZERO, upper_oe: 1'b0,
      strap_out: 1'b1, strap_oe: 1'b0, lock_n_out: 1'b1, lock_oe: 1'b0,
      rd_n: 1'b1, wr_n: 1'b1, ale: 1'b0, ctl_oe: 1'b0, pullup_en: 1'b1};
endpackage : reset_bus_pkg

// File: src/pin_sync.sv
// multi-bit two flip-flop synchroniser for asynchronous pin levels
// assumes each lane is an independent level; no word coherence is given
`timescale 1ns/1ps
module pin_sync
   import reset_bus_pkg::*;
#(
   parameter logic [SYNC_WIDTH-1:0] RST_VAL = SYNC_RESET_VAL
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // levels
   input wire logic [SYNC_WIDTH-1:0] i_async,
   output logic [SYNC_WIDTH-1:0] o_sync
);
   logic [SYNC_STAGES-1:0][SYNC_WIDTH-1:0] stage_reg;

   // first stage feeds only the second
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stage_reg <= {SYNC_STAGES{RST_VAL}};
      end else begin
         stage_reg <= {stage_reg[SYNC_STAGES-2:0], i_async};
      end
   end

   assign o_sync = stage_reg[SYNC_STAGES-1];
endmodule : pin_sync

// File: src/reset_bus_ctl.sv
// reset intake and bus pin state control for the processor bus unit
// assumes the reset pin and the strap input are asynchronous pins,
// and the core bus request arrives on i_clock
`timescale 1ns/1ps
module reset_bus_ctl
   import reset_bus_pkg::*;
(
   // clock and power-on reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // pins sampled from outside
   input wire logic i_reset_in_n,
   input wire logic i_top_addr_strap_pin,
   // core bus unit
   input wire core_bus_t i_core,
   output logic o_core_rst_n,
   output logic o_bus_abort,
   output logic o_test_float_mode,
   // pin drive
   output bus_pins_t o_pins
);
   typedef struct packed {
      seq_state_t state;
      logic core_rst_n;
      logic abort;
      logic test_float_mode;
      logic last_read;
      logic [1:0] float_cnt;
      bus_pins_t pins;
   } ctl_state_t;

   localparam ctl_state_t STATE_RESET = '{
      state: st_float, core_rst_n: 1'b0, abort: 1'b0, test_float_mode: 1'b0,
      last_read: 1'b0, float_cnt: 2'h0, pins: PINS_RESET};

   ctl_state_t s_reg;
   ctl_state_t s_next;
   logic [SYNC_WIDTH-1:0] sync_out;
   logic in_reset;
   logic strap_low;
   logic low_power;
   logic halt_case;

   pin_sync #(
      .RST_VAL(SYNC_RESET_VAL)
   ) u_sync (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_async({i_top_addr_strap_pin, i_reset_in_n}),
      .o_sync(sync_out)
   );

   assign in_reset = !sync_out[SYNC_RESET_BIT];
   assign strap_low = !sync_out[SYNC_STRAP_BIT];
   assign low_power = i_core.powerdown || i_core.idle;
   assign halt_case = (s_reg.state == st_run) && !in_reset && !s_reg.test_float_mode
      && !low_power && i_core.halt;

   always_comb begin
      s_next = s_reg;
      s_next.abort = 1'b0;
      unique case (s_reg.state)
         st_run: begin
            if (in_reset) begin
               s_next.state = st_park;
               s_next.abort = i_core.active;
               s_next.test_float_mode = 1'b0;
            end
         end
         st_park: begin
            s_next.state = st_float;
            s_next.float_cnt = 2'h0;
         end
         st_float: begin
            // the strap lane lags the pin by the sync depth; a short pulse would
            // otherwise latch the address bit this block drove on that pin in run
            if (s_reg.float_cnt != FLOAT_SETTLE) begin
               s_next.float_cnt = s_reg.float_cnt + 2'h1;
            end
            if (!in_reset && s_reg.float_cnt == FLOAT_SETTLE) begin
               s_next.state = st_run;
               // strap level as seen with the release edge, same sync depth
               s_next.test_float_mode = strap_low;
            end
         end
      endcase
      s_next.core_rst_n = (s_next.state == st_run);
      if (s_reg.state == st_run && i_core.active && (i_core.is_read || i_core.is_write)) begin
         s_next.last_read = i_core.is_read;
      end
      if (s_next.state != st_run) begin
         s_next.last_read = 1'b0;
      end

      // pin drive for the coming cycle
      s_next.pins = PINS_RESET;
      s_next.pins.pullup_en = 1'b0;
      s_next.pins.ad_out = s_reg.pins.ad_out;
      unique case (s_next.state)
         st_park: begin
            // controls inactive for one cycle before they float
            s_next.pins.ctl_oe = 1'b1;
            s_next.pins.lock_oe = 1'b1;
         end
         st_float: begin
            s_next.pins.pullup_en = 1'b1;
         end
         st_run: begin
            if (s_next.test_float_mode) begin
               // every output floats until the next reset
               s_next.pins.pullup_en = 1'b0;
            end else if (low_power) begin
               s_next.pins.ad_out = AD_ZERO;
               s_next.pins.ad_oe = 1'b1;
               s_next.pins.upper_out = UPPER_ZERO;
               s_next.pins.upper_oe = 1'b1;
               s_next.pins.strap_out = 1'b0;
               s_next.pins.strap_oe = 1'b1;
               s_next.pins.ctl_oe = 1'b1;
               s_next.pins.lock_oe = 1'b1;
            end else if (i_core.halt) begin
               // address content is invalid; old value is kept on the lines
               s_next.pins.ad_oe = !(i_core.t1 && s_reg.last_read);
               s_next.pins.upper_out = s_reg.pins.upper_out;
               s_next.pins.upper_oe = 1'b1;
               s_next.pins.strap_out = s_reg.pins.strap_out;
               s_next.pins.strap_oe = 1'b1;
               s_next.pins.ctl_oe = 1'b1;
               s_next.pins.lock_oe = 1'b1;
            end else begin
               s_next.pins.ad_out = i_core.ad;
               s_next.pins.ad_oe = i_core.ad_en;
               s_next.pins.upper_out = i_core.upper;
               s_next.pins.upper_oe = 1'b1;
               s_next.pins.strap_out = i_core.top_addr;
               s_next.pins.strap_oe = 1'b1;
               s_next.pins.lock_n_out = !i_core.lock;
               s_next.pins.lock_oe = 1'b1;
               s_next.pins.rd_n = !(i_core.active && i_core.is_read);
               s_next.pins.wr_n = !(i_core.active && i_core.is_write);
               s_next.pins.ale = i_core.ale;
               s_next.pins.ctl_oe = 1'b1;
            end
         end
      endcase
   end

   // async reset loads constants only; the pin reset arrives via the synchroniser
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_reg <= STATE_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_core_rst_n = s_reg.core_rst_n;
   assign o_bus_abort = s_reg.abort;
   assign o_test_float_mode = s_reg.test_float_mode;
   assign o_pins = s_reg.pins;

   // checks
   a_reset_holds_core: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      in_reset |=> !o_core_rst_n)
      else $error("core left reset while the reset pin was active");

   a_pin_reset_latency: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      $fell(i_reset_in_n) |-> ##[2:4] !o_core_rst_n)
      else $error("reset pin low not seen by the core within four cycles");

   a_release_synced: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      $rose(o_core_rst_n) |-> $past(sync_out[SYNC_RESET_BIT]) && $past(s_reg.state == st_float))
      else $error("core released without a synchronised deassertion");

   a_abort_then_float: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (s_reg.state == st_run) && in_reset && i_core.active |=>
      o_bus_abort && o_pins.ctl_oe && o_pins.rd_n && o_pins.wr_n && !o_pins.ad_oe
      ##1 !o_pins.ctl_oe && !o_pins.lock_oe)
      else $error("bus cycle not parked and floated on reset");

   a_reset_pullups: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      in_reset ##1 in_reset |=> o_pins.pullup_en && !o_pins.lock_oe && !o_pins.upper_oe
      && !o_pins.strap_oe)
      else $error("lock, strap or upper address pins driven during reset");

   a_strap_sample: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      $rose(o_core_rst_n) |-> o_test_float_mode == !$past(sync_out[SYNC_STRAP_BIT]))
      else $error("test float mode does not match strap level at release");

   a_strap_from_pullup: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      $rose(o_core_rst_n) |-> $past(o_pins.pullup_en, 3))
      else $error("strap level taken while the strap pin was not released");

   a_test_float_cleared: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      $fell(o_core_rst_n) |-> !o_test_float_mode)
      else $error("test float mode kept after a new reset");

   a_abort_one_cycle: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      o_bus_abort |=> !o_bus_abort)
      else $error("bus abort pulse longer than one cycle");

   a_test_float_quiet: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      o_test_float_mode |-> !o_pins.ad_oe && !o_pins.ctl_oe && !o_pins.upper_oe)
      else $error("outputs driven in test float mode");

   a_halt_ad_float: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      halt_case |=> o_pins.ad_oe == !($past(i_core.t1) && $past(s_reg.last_read)))
      else $error("muxed lines wrong in halt T1");

   a_halt_ctl_idle: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      halt_case |=> o_pins.ctl_oe && o_pins.rd_n && o_pins.wr_n && !o_pins.ale
      && o_pins.lock_n_out)
      else $error("control output active during halt");

   a_low_power_zero: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (s_reg.state == st_run) && !in_reset && !s_reg.test_float_mode && low_power |=>
      o_pins.ad_oe && o_pins.ad_out == AD_ZERO && o_pins.upper_out == UPPER_ZERO
      && o_pins.upper_oe)
      else $error("address lines not zero in powerdown or idle");

   c_warm_abort: cover property (@(posedge i_clock) disable iff (!i_rst_n)
      o_bus_abort ##1 o_pins.pullup_en);
   c_test_float_entry: cover property (@(posedge i_clock) disable iff (!i_rst_n)
      $rose(o_test_float_mode));
   c_halt_after_read: cover property (@(posedge i_clock) disable iff (!i_rst_n)
      halt_case && i_core.t1 && s_reg.last_read);
   c_low_power: cover property (@(posedge i_clock) disable iff (!i_rst_n)
      o_core_rst_n && low_power);
endmodule : reset_bus_ctl

// File: tb/reset_bus_partner.sv
// far-side model: outside reset circuit and the strap pull-down
// assumes the bench steers it through two command levels
`timescale 1ns/1ps
module reset_bus_partner
   import reset_bus_pkg::*;
(
   // commands and clock
   input wire logic i_clock,
   input wire logic i_hold_reset,
   input wire logic i_strap_low,
   // device pins
   input wire bus_pins_t i_pins,
   output logic o_reset_in_n,
   output logic o_strap_level
);
   logic float_pat_reg = 1'b0;
   // the bench holds the command high from time zero, so power-up starts in reset
   assign o_reset_in_n = ~i_hold_reset;
   // lock and upper lines are never pulled low here
   always_ff @(posedge i_clock) begin
      float_pat_reg <= ~float_pat_reg;
   end
   // an undriven line with no pullup must not look settled, so it toggles
   always_comb begin
      if (i_pins.strap_oe) begin
         o_strap_level = i_pins.strap_out;
      end else if (i_strap_low) begin
         o_strap_level = 1'b0;
      end else if (i_pins.pullup_en) begin
         o_strap_level = 1'b1;
      end else begin
         o_strap_level = float_pat_reg;
      end
   end
endmodule : reset_bus_partner

// File: tb/processor_reset_bus_state_ctl_tb_top.sv
// self-checking bench for the reset intake and bus-state control block
// assumes reset_bus_partner drives the reset and strap pins
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module processor_reset_bus_state_ctl_tb_top
   import reset_bus_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hold_reset = 1'b1;
   logic strap_low = 1'b0;
   core_bus_t core = '0;
   logic reset_in_n, strap_level, core_rst_n, bus_abort, test_float;
   bus_pins_t pins;
   int fail_count = 0;
   int n_compared = 0;

   reset_bus_ctl u_reset_bus_ctl (.i_clock(clk), .i_rst_n(rst_n),
      .i_reset_in_n(reset_in_n), .i_top_addr_strap_pin(strap_level), .i_core(core),
      .o_core_rst_n(core_rst_n), .o_bus_abort(bus_abort), .o_test_float_mode(test_float),
      .o_pins(pins));
   reset_bus_partner u_reset_bus_partner (.i_clock(clk), .i_hold_reset(hold_reset),
      .i_strap_low(strap_low), .i_pins(pins), .o_reset_in_n(reset_in_n),
      .o_strap_level(strap_level));

   initial begin
      forever #5 clk = ~clk;
   end

   task automatic tally_and_finish();
      if (fail_count == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   task automatic drive(input core_bus_t c);
      @(posedge clk);
      core <= c;
   endtask : drive

   task automatic settle();
      @(posedge clk);
      #1;
   endtask : settle

   // bounded poll, then one compare so a hang shows as a mismatch
   task automatic wait_rst(input logic v);
      for (int i = 0; i < 8 && core_rst_n !== v; i++) begin
         settle();
      end
      `CHK(core_rst_n, v)
   endtask : wait_rst

   task automatic power_on();
      repeat (4) @(posedge clk);
      settle();
      `CHK(core_rst_n, 1'b0)
      `CHK({pins.ad_oe, pins.upper_oe, pins.strap_oe}, 3'h0)
      `CHK({pins.lock_oe, pins.ctl_oe, pins.pullup_en}, 3'h1)
      @(posedge clk);
      hold_reset <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) settle();
      `CHK(core_rst_n, 1'b0)
      settle();
      `CHK(core_rst_n, 1'b1)
   endtask : power_on

   task automatic warm_reset(input logic strap, input logic active, input logic pulse);
      core_bus_t c;
      c = '0;
      c.active = active;
      c.is_read = 1'b1;
      c.ad = 16'h5a5a;
      drive(c);
      @(posedge clk);
      hold_reset <= 1'b1;
      strap_low <= strap;
      if (pulse) begin
         @(posedge clk);
         hold_reset <= 1'b0;
      end
      wait_rst(1'b0);
      `CHK(bus_abort, active)
      `CHK({pins.ctl_oe, pins.rd_n, pins.wr_n}, 3'h7)
      `CHK({pins.ale, pins.lock_oe, pins.lock_n_out}, 3'h3)
      `CHK({pins.ad_oe, pins.upper_oe, pins.strap_oe}, 3'h0)
      settle();
      `CHK(bus_abort, 1'b0)
      `CHK({pins.ctl_oe, pins.lock_oe, pins.pullup_en}, 3'h1)
      repeat (4) settle();
      if (!pulse) begin
         `CHK(core_rst_n, 1'b0)
      end
      @(posedge clk);
      core <= '0;
      hold_reset <= 1'b0;
      wait_rst(1'b1);
      `CHK(test_float, strap)
      `CHK(pins.pullup_en, 1'b0)
      @(posedge clk);
      strap_low <= 1'b0;
   endtask : warm_reset

   task automatic float_check();
      core_bus_t c;
      c = '0;
      c.powerdown = 1'b1;
      drive(c);
      settle();
      `CHK({pins.ad_oe, pins.upper_oe, pins.strap_oe, pins.ctl_oe, pins.lock_oe}, 5'h00)
   endtask : float_check

   task automatic halt_after(input logic was_read);
      core_bus_t c;
      c = '0;
      c.active = 1'b1;
      c.is_read = was_read;
      c.is_write = !was_read;
      c.ad_en = 1'b1;
      c.ad = 16'h1234;
      drive(c);
      c = '0;
      c.halt = 1'b1;
      c.t1 = 1'b1;
      c.ad_en = 1'b1;
      drive(c);
      settle();
      `CHK(pins.ad_oe, !was_read)
      `CHK({pins.ctl_oe, pins.rd_n, pins.wr_n, pins.ale, pins.lock_n_out}, 5'h1d)
   endtask : halt_after

   // powerdown then idle, each entered straight after a write with all-ones address
   task automatic low_power();
      core_bus_t c;
      for (int m = 0; m < 2; m++) begin
         c = '0;
         c.active = 1'b1;
         c.is_write = 1'b1;
         c.ad_en = 1'b1;
         c.ad = 16'hffff;
         c.upper = 3'h7;
         drive(c);
         c.active = 1'b0;
         c.is_write = 1'b0;
         c.powerdown = (m == 0);
         c.idle = (m == 1);
         drive(c);
         settle();
         `CHK({pins.ad_out, pins.upper_out}, 19'h0)
         `CHK({pins.ad_oe, pins.upper_oe}, 2'h3)
      end
   endtask : low_power

   initial begin
      power_on();
      halt_after(1'b1);
      halt_after(1'b0);
      low_power();
      warm_reset(1'b0, 1'b1, 1'b0);
      warm_reset(1'b0, 1'b1, 1'b1);
      warm_reset(1'b1, 1'b0, 1'b0);
      float_check();
      warm_reset(1'b0, 1'b0, 1'b0);
      low_power();
      tally_and_finish();
   end

   // whole run is about a hundred cycles; this is ample margin
   initial begin
      #50000;
      fail_count++;
      tally_and_finish();
   end
endmodule : processor_reset_bus_state_ctl_tb_top
